//--- inc/cgf_bank_if.sv
`timescale 1ns/100ps

// ****************************************************************
// Link between the fanout top and one bank gate
// ****************************************************************
interface cgf_bank_if
#(
  parameter int WIDTH = 5
);
  logic             fall_edge;
  logic             clk_level;
  logic             enable;
  logic [WIDTH-1:0] outputs;
  logic             active;

  modport top
  (
    output fall_edge,
    output clk_level,
    output enable,
    input  outputs,
    input  active
  );

  modport bank
  (
    input  fall_edge,
    input  clk_level,
    input  enable,
    output outputs,
    output active
  );
endinterface : cgf_bank_if

//--- inc/cgf_pkg.sv
// ****************************************************************
// Shared constants for the dual bank clock gate fanout
// ****************************************************************
package cgf_pkg;

  // ****************************************************************
  // Structure
  // ****************************************************************
  localparam int NUM_BANKS   = 2;
  localparam int BANK_WIDTH  = 5;
  localparam int SYNC_STAGES = 2;

  // Bank indices
  localparam int BANK_A_IDX = 0;
  localparam int BANK_B_IDX = 1;

  // ****************************************************************
  // Reset and output values
  // ****************************************************************
  localparam logic [BANK_WIDTH-1:0] OUT_RESET    = 5'h00;
  localparam logic [BANK_WIDTH-1:0] OUT_ALL_HIGH = 5'h1f;
  localparam logic                  SYNC_RESET   = 1'b0;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int MCLK_FREQ_MHZ       = 50;
  localparam int SRC_CLOCK_MAX_MHZ   = 200;
  // Sampled source needs at least two mclk per half period to be seen
  localparam int SRC_CLOCK_TRACK_MHZ = MCLK_FREQ_MHZ / 4;

  // ****************************************************************
  // Bank modes
  // ****************************************************************
  typedef enum logic
  {
    BANK_GATED,
    BANK_BUFFER
  } cgf_bank_mode_type;

endpackage : cgf_pkg

//--- rtl/cgf_bank_gate.sv
`timescale 1ns/100ps

// ****************************************************************
// One gated bank of clock copies
// ****************************************************************
module cgf_bank_gate
#(
  parameter int WIDTH = 5
)
(
  // Clock and reset
  input  wire logic   mclk,
  input  wire logic   reset_n,
  input  wire logic   clk_en,
  // Towards the top
  cgf_bank_if.bank    link
);

  cgf_pkg::cgf_bank_mode_type mode_q;
  cgf_pkg::cgf_bank_mode_type mode_d;
  logic [WIDTH-1:0]           out_q;
  logic [WIDTH-1:0]           out_d;

  // ****************************************************************
  // Mode and outputs
  // ****************************************************************
  always_comb
  begin
    mode_d = mode_q;
    if (link.fall_edge)
    begin
      // Mode only moves at a falling edge: clock is low then, no runt
      mode_d = link.enable ? cgf_pkg::BANK_BUFFER : cgf_pkg::BANK_GATED;
    end
    case (mode_d)
      cgf_pkg::BANK_BUFFER:
      begin
        out_d = {WIDTH{link.clk_level}};
      end
      cgf_pkg::BANK_GATED:
      begin
        out_d = '0;
      end
      default:
      begin
        out_d = '0;
      end
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      mode_q <= cgf_pkg::BANK_GATED;
      out_q  <= '0;
    end
    else if (clk_en)
    begin
      mode_q <= mode_d;
      out_q  <= out_d;
    end
  end

  assign link.outputs = out_q;
  assign link.active  = (mode_q == cgf_pkg::BANK_BUFFER);

endmodule : cgf_bank_gate

//--- rtl/cgf_fanout.sv
`timescale 1ns/100ps

// ****************************************************************
// Dual bank clock gate fanout
// ****************************************************************
module cgf_fanout
#(
  parameter int BANK_WIDTH = cgf_pkg::BANK_WIDTH
)
(
  // Clock and reset
  input  wire logic                  mclk,
  input  wire logic                  reset_n,
  input  wire logic                  clk_en,
  // Source clock pin
  input  wire logic                  src_clock,
  // Bank enable pins
  input  wire logic                  bank_a_enable,
  input  wire logic                  bank_b_enable,
  // Clock copies
  output logic [BANK_WIDTH-1:0]      bank_a_clock_outputs,
  output logic [BANK_WIDTH-1:0]      bank_b_clock_outputs,
  // Bank status
  output logic                       bank_a_active,
  output logic                       bank_b_active
);

  localparam int NB = cgf_pkg::NUM_BANKS;
  localparam int NS = NB + 1;

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  // Bit NB is the source clock, lower bits the bank enables
  logic [NS-1:0] pin_raw;
  logic [NS-1:0] sync1_q;
  logic [NS-1:0] sync1_d;
  logic [NS-1:0] sync2_q;
  logic [NS-1:0] sync2_d;
  logic          clk_hist_q;
  logic          clk_hist_d;
  logic          fall_edge;

  assign pin_raw[cgf_pkg::BANK_A_IDX] = bank_a_enable;
  assign pin_raw[cgf_pkg::BANK_B_IDX] = bank_b_enable;
  assign pin_raw[NB]                  = src_clock;

  always_comb
  begin
    sync1_d    = pin_raw;
    sync2_d    = sync1_q;
    clk_hist_d = sync2_q[NB];
  end

  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      sync1_q    <= '0;
      sync2_q    <= '0;
      clk_hist_q <= cgf_pkg::SYNC_RESET;
    end
    else if (clk_en)
    begin
      sync1_q    <= sync1_d;
      sync2_q    <= sync2_d;
      clk_hist_q <= clk_hist_d;
    end
  end

  // ****************************************************************
  // Source falling edge
  // ****************************************************************
  // Sampled detection: source faster than the tracking limit aliases
  assign fall_edge = clk_hist_q & ~sync2_q[NB] & clk_en;

  // ****************************************************************
  // Banks
  // ****************************************************************
  logic [BANK_WIDTH-1:0] bank_out [NB];
  logic [NB-1:0]         bank_act;

  generate
    for (genvar g = 0; g < NB; g++)
    begin : gen_bank
      cgf_bank_if #(.WIDTH(BANK_WIDTH)) link ();

      assign link.fall_edge = fall_edge;
      assign link.clk_level = sync2_q[NB];
      assign link.enable    = sync2_q[g];
      assign bank_out[g]    = link.outputs;
      assign bank_act[g]    = link.active;

      cgf_bank_gate
      #(
        .WIDTH   (BANK_WIDTH)
      )
      u_gate
      (
        .mclk    (mclk),
        .reset_n (reset_n),
        .clk_en  (clk_en),
        .link    (link)
      );
    end
  endgenerate

  // Ten copies, five per bank
  assign bank_a_clock_outputs = bank_out[cgf_pkg::BANK_A_IDX];
  assign bank_b_clock_outputs = bank_out[cgf_pkg::BANK_B_IDX];
  assign bank_a_active        = bank_act[cgf_pkg::BANK_A_IDX];
  assign bank_b_active        = bank_act[cgf_pkg::BANK_B_IDX];

endmodule : cgf_fanout

//--- tb/cgf_fanout_tb.sv
`timescale 1ns/100ps
// ****
// Fanout bench
// ****
module cgf_fanout_tb;
  logic       mclk, reset_n = 0, clk_en = 1, run = 0, src_clock, bank_a_active, bank_b_active;
  logic       bank_a_enable = 1, bank_b_enable = 1;
  logic [4:0] bank_a_clock_outputs, bank_b_clock_outputs;
  logic [3:0] half = 4'h7;
  logic [3:0] rows [4] = '{4'h0, 4'ha, 4'h5, 4'hf};
  int         n_mismatch = 0, check_count = 0;
  cgf_src_model cgf_src_model_i (.mclk, .run, .half, .src_clock);
  cgf_fanout cgf_fanout_i (.mclk, .reset_n, .clk_en, .src_clock, .bank_a_enable, .bank_b_enable,
    .bank_a_clock_outputs, .bank_b_clock_outputs, .bank_a_active, .bank_b_active);
  initial
  begin
    mclk = 0;
    forever #10 mclk = ~mclk;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : cyc
  task automatic finish_test();
    if (n_mismatch == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : finish_test
  task automatic cmp(input logic [11:0] exp);
    check_count++;
    if ({bank_a_active, bank_b_active, bank_a_clock_outputs, bank_b_clock_outputs} !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: outputs, expected %h", $time, exp);
    end
  endtask : cmp
  task automatic wait_st(input logic [2:0] want);
    int i;
    for (i = 0; i < 200 && {bank_a_active, bank_b_active, src_clock} !== want; i++)
      cyc(1);
    if (i == 200)
    begin
      n_mismatch++;
      $display("wrong value at %0t: timeout waiting for %b", $time, want);
      finish_test();
    end
  endtask : wait_st
  initial
  begin
    cyc(6);
    cmp(12'h000);
    reset_n = 1;
    cyc(12);
    cmp(12'h000);
    run = 1;
    foreach (rows[r])
    begin
      {bank_a_enable, bank_b_enable} = rows[r][3:2];
      wait_st({rows[r][1:0], 1'b1});
      cyc(4);
      cmp({rows[r][1:0], {5{rows[r][1]}}, {5{rows[r][0]}}});
    end
    // Enables dropped while parked must not act
    run = 0;
    cyc(10);
    {bank_a_enable, bank_b_enable} = 2'b00;
    cyc(10);
    cmp(12'hc00);
    run = 1;
    wait_st(3'b001);
    half = 4'h2;
    {bank_a_enable, bank_b_enable} = 2'b10;
    wait_st(3'b101);
    run = 0;
    cyc(10);
    // Frozen: source edges and enable changes must not be taken
    clk_en = 0;
    {bank_a_enable, bank_b_enable} = 2'b01;
    run = 1;
    cyc(30);
    run = 0;
    cyc(10);
    cmp(12'h800);
    clk_en = 1;
    cyc(6);
    cmp(12'h800);
    reset_n = 0;
    cyc(2);
    cmp(12'h000);
    reset_n = 1;
    cyc(2);
    finish_test();
  end
endmodule : cgf_fanout_tb
bind cgf_fanout cgf_monitor #(.BANK_WIDTH(BANK_WIDTH)) cgf_monitor_i (.mclk, .reset_n, .clk_en, .src_clock,
  .bank_a_enable, .bank_b_enable, .bank_a_clock_outputs, .bank_b_clock_outputs, .bank_a_active, .bank_b_active);

//--- tb/cgf_monitor.sv
`timescale 1ns/100ps
// ****
// Port checker
// ****
module cgf_monitor
#(
  parameter int BANK_WIDTH = 5
)
(
  // Clock and reset
  input wire logic                  mclk,
  input wire logic                  reset_n,
  input wire logic                  clk_en,
  // Pins
  input wire logic                  src_clock,
  input wire logic                  bank_a_enable,
  input wire logic                  bank_b_enable,
  input wire logic [BANK_WIDTH-1:0] bank_a_clock_outputs,
  input wire logic [BANK_WIDTH-1:0] bank_b_clock_outputs,
  input wire logic                  bank_a_active,
  input wire logic                  bank_b_active
);
  logic [4:0] src_q;
  logic       fa;
  logic       fb;
  // Sync depth is the design's choice, so a lag of 3 or 4 is accepted
  assign fa = src_q[3] & ~src_q[2];
  assign fb = src_q[4] & ~src_q[3];
  always_ff @(posedge mclk)
    src_q <= {src_q[3:0], src_clock};
  default clocking @(posedge mclk); endclocking
  // Frozen design lags the free-running source history, so checks pause
  default disable iff (!reset_n || !clk_en);
  property p_low_a; !bank_a_active |-> bank_a_clock_outputs == '0; endproperty
  a_low_a: assert property (p_low_a) else $error("bank a not low");
  property p_low_b; !bank_b_active |-> bank_b_clock_outputs == '0; endproperty
  a_low_b: assert property (p_low_b) else $error("bank b not low");
  property p_mode_a; fb |-> bank_a_active == $past(bank_a_enable, 4); endproperty
  a_mode_a: assert property (p_mode_a) else $error("bank a mode");
  property p_mode_b; fb |-> bank_b_active == $past(bank_b_enable, 4); endproperty
  a_mode_b: assert property (p_mode_b) else $error("bank b mode");
  property p_hold_a; !fa && !fb |-> $stable(bank_a_active); endproperty
  a_hold_a: assert property (p_hold_a) else $error("bank a switched");
  property p_hold_b; !fa && !fb |-> $stable(bank_b_active); endproperty
  a_hold_b: assert property (p_hold_b) else $error("bank b switched");
  property p_copy_a;
    bank_a_active && $past(bank_a_active) && src_q[2] == src_q[3] |-> bank_a_clock_outputs == {BANK_WIDTH{src_q[2]}};
  endproperty
  a_copy_a: assert property (p_copy_a) else $error("bank a copy");
  property p_copy_b;
    bank_b_active && $past(bank_b_active) && src_q[2] == src_q[3] |-> bank_b_clock_outputs == {BANK_WIDTH{src_q[2]}};
  endproperty
  a_copy_b: assert property (p_copy_b) else $error("bank b copy");
endmodule : cgf_monitor

//--- tb/cgf_src_model.sv
`timescale 1ns/100ps
// ****
// Source clock, parked low when idle
// ****
module cgf_src_model
(
  // Control
  input wire logic       mclk,
  input wire logic       run,
  input wire logic [3:0] half,
  // Source pin
  output logic           src_clock = 1'b0
);
  int cnt = 0;
  // Two cycles per half period at least, else the pin is not trackable
  always @(posedge mclk)
  begin
    cnt <= (run && cnt < half - 1) ? cnt + 1 : 0;
    src_clock <= run && (src_clock ^ (cnt == half - 1));
  end
endmodule : cgf_src_model
